// *** include/card_slot_params.svh ***
// register indices, field positions, reset values and bus codes of the slot control bank
`ifndef CARD_SLOT_PARAMS_SVH
`define CARD_SLOT_PARAMS_SVH

// register indices and first slot number; byte address is four times the index
`define SLOT_CTRL_IDX       8'h03
`define SLOT_BANK_SEL_IDX   8'h40
`define SLOT_AUX_IDX        8'h42
`define FIRST_SLOT_NUM      8'h03

// control register fields
`define CTRL_LOW_V_BIT      7
`define CTRL_IO_EN_BIT      6
`define CTRL_PAGE_HI        5
`define CTRL_PAGE_LO        4
`define CTRL_CLOCK_POWERDOWN_SELECT_BIT       3
`define CTRL_HIGH_V_BIT     2
`define CTRL_WARM_BIT       1
`define CTRL_START_BIT      0

// page 00 auxiliary fields
`define AUX_RST_BIT         6
`define AUX_IDLE_HI         3
`define AUX_IDLE_LO         2
`define AUX_DIV_HI          1
`define AUX_DIV_LO          0

// page codes
`define PAGE_CTRL           2'b00
`define PAGE_SHORT_CNT      2'b01
`define PAGE_LONG_HI        2'b10
`define PAGE_LONG_LO        2'b11

// reset values
`define SHORT_CNT_RST       8'hAA
`define LONG_HI_RST         8'hA4
`define LONG_LO_RST         8'h74
`define BANK_SEL_RST        8'h03

// bus response codes
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// *** include/card_slot_pkg.sv ***
// types shared by the slot control bank and its per-slot logic
package card_slot_pkg;

	typedef enum logic [1:0] {VCC_3V, VCC_5V, VCC_1V8} vcc_level_type;

	typedef enum logic [2:0] {CLK_LOW, CLK_HIGH, CLK_OSC_HALF,
		CLK_EXT_DIV1, CLK_EXT_DIV2, CLK_EXT_DIV4, CLK_EXT_DIV5} clk_mode_type;

	// per-slot status from the analog side and answer-to-reset logic
	typedef struct packed {
		logic supervisor_fault;
		logic protection_fault;
		logic card_presence;
		logic card_mute;
		logic start_bit_seen;
		logic sync_mode;
		logic atr_reset_level;
	} slot_status_type;

	// per-slot drive toward the card side
	typedef struct packed {
		vcc_level_type vcc_level;
		logic          io_connect;
		clk_mode_type  clk_mode;
		logic          card_reset;
		logic          activate;
		logic          deactivate;
		logic          warm_start;
	} card_drive_type;

endpackage

// *** design/slot_ctrl.sv ***
// per-slot control and auxiliary page 00 bits for one card slot
`timescale 1ns/10ps
`include "card_slot_params.svh"
module slot_ctrl
	import card_slot_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      arst_n,
	input  wire logic                      ctrl_wr,
	input  wire logic                      aux_wr,
	input  wire logic [7:0]                wr_byte,
	input  wire card_slot_pkg::slot_status_type status,
	output logic      [1:0]                page,
	output logic      [7:0]                aux_rd,
	output logic                           active,
	output card_slot_pkg::card_drive_type  card
);
	logic       low_v_r, high_v_r, io_en_r, clock_powerdown_select_r, warm_r, start_r, rst_r;
	logic [1:0] page_r, idle_r, div_r;
	logic       start_ok;
	clk_mode_type clk_nxt;

	assign start_ok = !status.supervisor_fault && !status.protection_fault
		&& status.card_presence;

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// locked bits keep their value; the rest of the byte still lands
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			low_v_r  <= 1'b0;
			high_v_r <= 1'b0;
			io_en_r  <= 1'b0;
			clock_powerdown_select_r   <= 1'b0;
			page_r   <= `PAGE_CTRL;
		end
		else if (ctrl_wr)
		begin
			io_en_r <= wr_byte[`CTRL_IO_EN_BIT];
			page_r  <= wr_byte[`CTRL_PAGE_HI:`CTRL_PAGE_LO];
			if (!start_r)
			begin
				low_v_r  <= wr_byte[`CTRL_LOW_V_BIT];
				high_v_r <= wr_byte[`CTRL_HIGH_V_BIT];
			end
			if (!(status.sync_mode && start_r))
				clock_powerdown_select_r <= wr_byte[`CTRL_CLOCK_POWERDOWN_SELECT_BIT];
		end
	end

	// activation only with clean status and a card present
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			start_r <= 1'b0;
		else if (ctrl_wr && wr_byte[`CTRL_START_BIT] && start_ok)
			start_r <= 1'b1;
		else if (ctrl_wr && !wr_byte[`CTRL_START_BIT])
			start_r <= 1'b0;
	end

	// software set wins over a hardware clear in the same cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			warm_r <= 1'b0;
		else if (ctrl_wr && wr_byte[`CTRL_WARM_BIT])
			warm_r <= 1'b1;
		else if (status.start_bit_seen || status.card_mute)
			warm_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// page 00 auxiliary bits
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			idle_r <= 2'b00;
			div_r  <= 2'b00;
			rst_r  <= 1'b0;
		end
		else
		begin
			if (aux_wr)
			begin
				idle_r <= wr_byte[`AUX_IDLE_HI:`AUX_IDLE_LO];
				div_r  <= wr_byte[`AUX_DIV_HI:`AUX_DIV_LO];
			end
			if (!status.sync_mode)
				rst_r <= status.atr_reset_level;
			else if (aux_wr)
				rst_r <= wr_byte[`AUX_RST_BIT];
		end
	end

	// clock source choice; sync mode only knows low and high
	always_comb
	begin
		clk_nxt = CLK_EXT_DIV1;
		if (status.sync_mode)
			clk_nxt = (clock_powerdown_select_r && idle_r[0]) ? CLK_HIGH : CLK_LOW;
		else if (clock_powerdown_select_r && idle_r != 2'b11)
		begin
			case (idle_r)
				2'b00:   clk_nxt = CLK_LOW;
				2'b01:   clk_nxt = CLK_HIGH;
				default: clk_nxt = CLK_OSC_HALF;
			endcase
		end
		else
		begin
			case (div_r)
				2'b00:   clk_nxt = CLK_EXT_DIV1;
				2'b01:   clk_nxt = CLK_EXT_DIV2;
				2'b10:   clk_nxt = CLK_EXT_DIV4;
				default: clk_nxt = CLK_EXT_DIV5;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registered drive toward the card
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			card <= '{vcc_level: VCC_3V, clk_mode: CLK_LOW, default: 1'b0};
		else
		begin
			card.vcc_level  <= low_v_r ? VCC_1V8 : (high_v_r ? VCC_5V : VCC_3V);
			card.io_connect <= io_en_r;
			card.clk_mode   <= clk_nxt;
			card.card_reset <= rst_r;
			card.activate   <= ctrl_wr && wr_byte[`CTRL_START_BIT] && start_ok;
			card.deactivate <= ctrl_wr && !wr_byte[`CTRL_START_BIT];
			card.warm_start <= ctrl_wr && wr_byte[`CTRL_WARM_BIT];
		end
	end

	assign page   = page_r;
	assign active = start_r;
	assign aux_rd = {1'b0, rst_r, 2'b00, idle_r, div_r};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_start_refused: assert property (ctrl_wr && !start_ok && !start_r |=> !start_r)
		else $error("start accepted with a fault or no card");
	a_voltage_lock: assert property (start_r && ctrl_wr |=> $stable(low_v_r) && $stable(high_v_r))
		else $error("voltage select changed while slot active");
	a_low_volt_out: assert property (low_v_r |=> card.vcc_level == VCC_1V8)
		else $error("low voltage select not applied");
	a_warm_set_wins: assert property (ctrl_wr && wr_byte[`CTRL_WARM_BIT] |=> warm_r)
		else $error("warm reset request lost");
	a_warm_hw_clear: assert property (!ctrl_wr && (status.card_mute || status.start_bit_seen)
		|=> !warm_r)
		else $error("warm reset bit not cleared by hardware");
	sequence deact_req;
		ctrl_wr && !wr_byte[`CTRL_START_BIT];
	endsequence
	a_deact_pulse: assert property (deact_req |=> card.deactivate && !start_r ##1 !card.deactivate)
		else $error("deactivation not signalled once");
	a_clock_powerdown_select_lock: assert property (status.sync_mode && start_r && ctrl_wr |=> $stable(clock_powerdown_select_r))
		else $error("power-down bit written in sync mode while active");
endmodule

// *** design/card_slot_control_regs.sv ***
// slot control register bank for card slots 3 to 5 behind an axi4-lite slave
`timescale 1ns/10ps
`include "card_slot_params.svh"
module card_slot_control_regs
	import card_slot_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int NSLOT  = 3
)
(
	input  wire logic                                clk,
	input  wire logic                                arst_n,
	input  wire logic [ADDR_W-1:0]                   s_axi_awaddr,
	input  wire logic                                s_axi_awvalid,
	output logic                                     s_axi_awready,
	input  wire logic [31:0]                         s_axi_wdata,
	input  wire logic [3:0]                          s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output logic                                     s_axi_wready,
	output logic [1:0]                               s_axi_bresp,
	output logic                                     s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	input  wire logic [ADDR_W-1:0]                   s_axi_araddr,
	input  wire logic                                s_axi_arvalid,
	output logic                                     s_axi_arready,
	output logic [31:0]                              s_axi_rdata,
	output logic [1:0]                               s_axi_rresp,
	output logic                                     s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	input  wire card_slot_pkg::slot_status_type [NSLOT-1:0] slot_status,
	output card_slot_pkg::card_drive_type [NSLOT-1:0]  card_drive,
	output logic [7:0]                               short_count,
	output logic [15:0]                              long_count
);
	// ----------------------------------------------------------------
	// write channel capture
	// ----------------------------------------------------------------
	logic              aw_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic              w_held_r;
	logic [7:0]        w_byte_r;
	logic              w_lane0_r;
	logic              wr_go;

	// address and data may arrive in either order
	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_held_r     <= 1'b0;
			aw_addr_r     <= '0;
			s_axi_awready <= 1'b1;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_r     <= 1'b1;
			aw_addr_r     <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else if (wr_go)
		begin
			aw_held_r     <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			w_held_r     <= 1'b0;
			w_byte_r     <= 8'h00;
			w_lane0_r    <= 1'b0;
			s_axi_wready <= 1'b1;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_r     <= 1'b1;
			w_byte_r     <= s_axi_wdata[7:0];
			w_lane0_r    <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end
		else if (wr_go)
		begin
			w_held_r     <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic       wr_hi_zero;
	logic       rd_hi_zero;
	logic [7:0] bank_sel_r;
	logic [7:0] sel_off;
	logic       sel_ok;
	logic [1:0] sel_page;

	assign wr_idx     = aw_addr_r[9:2];
	assign rd_idx     = s_axi_araddr[9:2];
	assign wr_hi_zero = (aw_addr_r[ADDR_W-1:10] == '0) && (aw_addr_r[1:0] == 2'b00);
	assign rd_hi_zero = (s_axi_araddr[ADDR_W-1:10] == '0) && (s_axi_araddr[1:0] == 2'b00);

	// second register reaches only the slot named by the bank select
	assign sel_off = bank_sel_r - `FIRST_SLOT_NUM;
	assign sel_ok  = (bank_sel_r >= `FIRST_SLOT_NUM) && (sel_off < 8'(NSLOT));

	logic [NSLOT-1:0]      ctrl_wr;
	logic [NSLOT-1:0]      aux_wr;
	logic [NSLOT-1:0][1:0] slot_page;
	logic [NSLOT-1:0][7:0] slot_aux;
	logic [NSLOT-1:0]      slot_active;
	logic                  wr_ctrl_hit;
	logic                  wr_hit;
	logic                  wr_aux;
	logic                  rd_hit;
	logic [7:0]            rd_byte;

	assign sel_page    = sel_ok ? slot_page[sel_off[1:0]] : `PAGE_CTRL;
	assign wr_ctrl_hit = wr_hi_zero && (wr_idx >= `SLOT_CTRL_IDX)
		&& (wr_idx < `SLOT_CTRL_IDX + 8'(NSLOT));
	assign wr_aux      = wr_hi_zero && (wr_idx == `SLOT_AUX_IDX) && sel_ok;
	assign wr_hit      = wr_ctrl_hit || wr_aux
		|| (wr_hi_zero && wr_idx == `SLOT_BANK_SEL_IDX);

	// strobes into each slot, only for an accepted low-lane write
	generate
		for (genvar i = 0; i < NSLOT; i++)
		begin : g_slot
			assign ctrl_wr[i] = wr_go && w_lane0_r && wr_hi_zero
				&& (wr_idx == `SLOT_CTRL_IDX + 8'(i));
			assign aux_wr[i]  = wr_go && w_lane0_r && wr_aux
				&& (sel_off == 8'(i)) && (slot_page[i] == `PAGE_CTRL);

			slot_ctrl u_slot
			(
				.clk     (clk),
				.arst_n  (arst_n),
				.ctrl_wr (ctrl_wr[i]),
				.aux_wr  (aux_wr[i]),
				.wr_byte (w_byte_r),
				.status  (slot_status[i]),
				.page    (slot_page[i]),
				.aux_rd  (slot_aux[i]),
				.active  (slot_active[i]),
				.card    (card_drive[i])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// bank select and shared counters
	// ----------------------------------------------------------------
	logic lane_wr;

	assign lane_wr = wr_go && w_lane0_r;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			bank_sel_r <= `BANK_SEL_RST;
		else if (lane_wr && wr_hi_zero && wr_idx == `SLOT_BANK_SEL_IDX)
			bank_sel_r <= w_byte_r;
	end

	// counter pages are shared by every slot
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			short_count <= `SHORT_CNT_RST;
			long_count  <= {`LONG_HI_RST, `LONG_LO_RST};
		end
		else if (lane_wr && wr_aux)
		begin
			case (sel_page)
				`PAGE_SHORT_CNT: short_count       <= w_byte_r;
				`PAGE_LONG_HI:   long_count[15:8]  <= w_byte_r;
				`PAGE_LONG_LO:   long_count[7:0]   <= w_byte_r;
				default:         short_count       <= short_count;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// write response
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [7:0] rd_slot;
	logic       rd_ctrl;

	assign rd_slot = rd_idx - `SLOT_CTRL_IDX;
	assign rd_ctrl = rd_hi_zero && (rd_idx >= `SLOT_CTRL_IDX)
		&& (rd_idx < `SLOT_CTRL_IDX + 8'(NSLOT));

	// control offsets read back slot status, not the written bits
	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit  = 1'b0;
		if (rd_ctrl)
		begin
			rd_hit  = 1'b1;
			rd_byte = {slot_active[rd_slot[1:0]], 1'b0,
				slot_status[rd_slot[1:0]].card_mute,
				slot_status[rd_slot[1:0]].protection_fault,
				slot_status[rd_slot[1:0]].supervisor_fault, 3'b000};
		end
		else if (rd_hi_zero && rd_idx == `SLOT_BANK_SEL_IDX)
		begin
			rd_hit  = 1'b1;
			rd_byte = bank_sel_r;
		end
		else if (rd_hi_zero && rd_idx == `SLOT_AUX_IDX && sel_ok)
		begin
			rd_hit = 1'b1;
			case (sel_page)
				`PAGE_CTRL:      rd_byte = slot_aux[sel_off[1:0]];
				`PAGE_SHORT_CNT: rd_byte = short_count;
				`PAGE_LONG_HI:   rd_byte = long_count[15:8];
				default:         rd_byte = long_count[7:0];
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_byte};
			s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence write_taken;
		wr_go;
	endsequence
	// a taken response must drop at the next edge, never linger
	sequence resp_held;
		s_axi_bvalid && s_axi_bready ##1 !s_axi_bvalid;
	endsequence

	a_write_answer: assert property (write_taken |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write not answered one cycle after both halves held");
	a_bresp_stable: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_bresp_taken: assert property (s_axi_bvalid && s_axi_bready |-> resp_held)
		else $error("write response not released after taken");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready)
		else $error("read not answered on the next cycle");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && !rd_hit
		|=> s_axi_rresp == `RESP_SLVERR)
		else $error("unmapped read not flagged");
	a_counter_page: assert property (lane_wr && wr_aux && sel_page == `PAGE_SHORT_CNT
		|=> short_count == $past(w_byte_r))
		else $error("short counter page write lost");
	a_aux_page_only: assert property (lane_wr && wr_aux && sel_page != `PAGE_CTRL
		|-> aux_wr == '0)
		else $error("page 00 bits written through a counter page");
endmodule

// *** tb/card_side_model.sv ***
// card-side model: faults, presence and answer-to-reset timing of slots 3 to 5
`timescale 1ns/10ps
module card_side_model
	import card_slot_pkg::*;
#(
	parameter int DLY = 6
)
(
	input  wire logic                                clk,
	input  wire logic                                arst_n,
	input  wire card_slot_pkg::card_drive_type [2:0] drive,
	input  wire logic [2:0]                          fault,
	input  wire logic                                sync,
	output card_slot_pkg::slot_status_type [2:0]     status
);
	int   wait_c [3];
	logic atr_r  [3];
	logic sb_r   [3];
	// ----
	// card answer
	// ----
	// the card answers a fixed delay after activation or warm reset
	always @(posedge clk or negedge arst_n)
	begin
		for (int i = 0; i < 3; i++)
		begin
			sb_r[i] <= 1'b0;
			if (!arst_n)
			begin
				wait_c[i] <= 0;
				atr_r[i]  <= 1'b0;
			end
			else if (drive[i].activate || drive[i].warm_start)
				wait_c[i] <= DLY;
			else if (drive[i].deactivate)
			begin
				wait_c[i] <= 0;
				atr_r[i]  <= 1'b0;
			end
			else if (wait_c[i] == 1)
			begin
				wait_c[i] <= 0;
				atr_r[i]  <= 1'b1;
				sb_r[i]   <= 1'b1;
			end
			else if (wait_c[i] > 1)
				wait_c[i] <= wait_c[i] - 1;
		end
	end
	// fault bits are {supervisor, protection, card absent}, shared by all slots
	always_comb
		for (int i = 0; i < 3; i++)
			status[i] = '{fault[2], fault[1], !fault[0], 1'b0, sb_r[i], sync, atr_r[i]};
endmodule

// *** tb/tb.sv ***
// self-checking bench for the slot control bank and its card-side model
`timescale 1ns/10ps
module tb;
	import card_slot_pkg::*;
	logic                  clk = 1'b0;
	logic                  arst_n = 1'b0;
	logic [11:0]           awaddr = '0;
	logic [11:0]           araddr = '0;
	logic [31:0]           wdata = '0;
	logic [3:0]            wstrb = 4'hF;
	logic [3:0]            strb = 4'hF;
	logic                  awvalid = 1'b0;
	logic                  wvalid = 1'b0;
	logic                  arvalid = 1'b0;
	logic                  bready = 1'b1;
	logic                  rready = 1'b1;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic [1:0]            bresp, rresp;
	logic [31:0]           rdata;
	logic [2:0]            fault = 3'b000;
	logic                  sync = 1'b0;
	slot_status_type [2:0] slot_status;
	card_drive_type [2:0]  card_drive;
	logic [7:0]            short_count;
	logic [15:0]           long_count;
	logic [7:0]            v;
	logic [7:0]            cnt [4];
	logic [7:0]            rst_tab [4] = '{8'h00, 8'hAA, 8'hA4, 8'h74};
	logic [7:0]            st_tab [4] = '{8'h08, 8'h10, 8'h00, 8'h80};
	int                    failures = 0, samples_checked = 0, cycles = 0, s, n;
	int                    act_n [3] = '{0, 0, 0};
	int                    deact_n [3] = '{0, 0, 0};
	int                    warm_n [3] = '{0, 0, 0};
	int                    seed = 32'hD25D72BC;

	card_slot_control_regs DUT (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .slot_status(slot_status), .card_drive(card_drive),
		.short_count(short_count), .long_count(long_count));
	card_side_model cards (.clk(clk), .arst_n(arst_n), .drive(card_drive),
		.fault(fault), .sync(sync), .status(slot_status));

	// ----
	// clock, watchdog, pulse counters
	// ----
	always #4 clk = ~clk;
	// pulses last one cycle, so they are counted rather than sampled later
	always @(posedge clk)
	begin
		cycles++;
		for (int i = 0; i < 3; i++)
		begin
			act_n[i]   += card_drive[i].activate;
			deact_n[i] += card_drive[i].deactivate;
			warm_n[i]  += card_drive[i].warm_start;
		end
		if (cycles == 20000)
		begin
			failures++;
			finish_test;
		end
	end
	// ----
	// tasks and expectations
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
	endtask
	// each channel drops valid at the edge that takes it
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		awaddr  <= {2'b00, idx, 2'b00};
		wdata   <= {24'h0, d};
		wstrb   <= strb;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		chk(32'(bresp), 32'(er));
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
		araddr  <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		chk(rdata, exp);
		chk(32'(rresp), 32'(er));
	endtask
	function automatic vcc_level_type vexp(input logic [7:0] c);
		return c[7] ? VCC_1V8 : (c[2] ? VCC_5V : VCC_3V);
	endfunction
	function automatic clk_mode_type cexp(input logic p, input logic [3:0] a);
		if (p && a[3:2] != 2'b11)
			return clk_mode_type'(a[3:2]);
		return clk_mode_type'(3'd3 + a[1:0]);
	endfunction
	// ----
	// main sequence
	// ----
	initial
	begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rchk(8'h40, 32'h3, 2'b00);
		for (int p = 1; p < 4; p++)
		begin
			wr(8'h03, {2'b00, 2'(p), 4'h0}, 2'b00);
			rchk(8'h42, 32'(rst_tab[p]), 2'b00);
			v = 8'($random(seed));
			wr(8'h42, v, 2'b00);
			rchk(8'h42, 32'(v), 2'b00);
			cnt[p] = v;
		end
		chk(32'(short_count), 32'(cnt[1]));
		chk(32'(long_count), {16'h0, cnt[2], cnt[3]});
		wr(8'h10, 8'hFF, 2'b10);
		rchk(8'h10, 32'h0, 2'b10);
		strb = 4'h0;
		wr(8'h40, 8'h05, 2'b00);
		strb = 4'hF;
		rchk(8'h40, 32'h3, 2'b00);
		wr(8'h40, 8'h07, 2'b00);
		wr(8'h42, 8'h01, 2'b10);
		// supply and io switching, one io line open at a time
		for (int t = 0; t < 24; t++)
		begin
			s = t / 8;
			v = (8'($random(seed)) & 8'h40) | {t[2], 4'h0, t[1], 2'b00};
			wr(8'(3 + s), v, 2'b00);
			settle;
			chk(32'(card_drive[s].vcc_level), 32'(vexp(v)));
			chk(32'(card_drive[s].io_connect), 32'(v[6]));
			if (t % 8 == 7)
				wr(8'(3 + s), 8'h00, 2'b00);
		end
		// every idle and divider code with and without power-down
		for (int k = 0; k < 32; k++)
		begin
			s = k % 3;
			wr(8'h40, 8'(3 + s), 2'b00);
			wr(8'(3 + s), {4'h0, k[4], 3'b000}, 2'b00);
			wr(8'h42, (8'($random(seed)) & 8'hB0) | 8'(k[3:0]), 2'b00);
			settle;
			chk(32'(card_drive[s].clk_mode), 32'(cexp(k[4], 4'(k))));
			rchk(8'h42, 32'(k[3:0]), 2'b00);
		end
		// start refused for each fault, then accepted
		wr(8'h40, 8'h03, 2'b00);
		for (int c = 0; c < 4; c++)
		begin
			fault <= 3'b100 >> c;
			settle;
			n = act_n[0];
			wr(8'h03, 8'h01, 2'b00);
			settle;
			chk(32'(act_n[0] - n), 32'(c == 3));
			rchk(8'h03, 32'(st_tab[c]), 2'b00);
		end
		wr(8'h42, 8'h00, 2'b00);
		repeat (10) @(posedge clk);
		chk(32'(card_drive[0].card_reset), 32'h1);
		wr(8'h03, 8'hC5, 2'b00);
		settle;
		chk(32'(card_drive[0].vcc_level), 32'(VCC_3V));
		chk(32'(card_drive[0].io_connect), 32'h1);
		n = warm_n[0];
		wr(8'h03, 8'h03, 2'b00);
		settle;
		chk(32'(warm_n[0] - n), 32'h1);
		n = deact_n[0];
		wr(8'h03, 8'h00, 2'b00);
		settle;
		chk(32'(deact_n[0] - n), 32'h1);
		rchk(8'h03, 32'h0, 2'b00);
		// synchronous mode: reset line and power-down lock
		sync <= 1'b1;
		wr(8'h42, 8'hFF, 2'b00);
		settle;
		chk(32'(card_drive[0].card_reset), 32'h1);
		rchk(8'h42, 32'h4F, 2'b00);
		wr(8'h42, 8'h34, 2'b00);
		settle;
		chk(32'(card_drive[0].card_reset), 32'h0);
		wr(8'h03, 8'h09, 2'b00);
		settle;
		chk(32'(card_drive[0].clk_mode), 32'(CLK_HIGH));
		wr(8'h03, 8'h01, 2'b00);
		settle;
		chk(32'(card_drive[0].clk_mode), 32'(CLK_HIGH));
		finish_test;
	end
endmodule
